// ==== verilog/fis_pkg.sv ====
// Constants and types shared by the front-end instruction sequencer
package fis_pkg;

  // ==========================================================================
  // Instruction store geometry
  localparam int FIS_DEPTH   = 4096;
  localparam int FIS_ADDR_W  = 12;
  localparam int FIS_WORD_W  = 22;
  localparam int FIS_FE_W    = 20;
  localparam int FIS_PARAM_W = 16;

  // ==========================================================================
  // Field positions inside one instruction word
  localparam int FIS_TYPE_HI      = 21;
  localparam int FIS_TYPE_LO      = 20;
  localparam int FIS_FE_HI        = 19;
  localparam int FIS_CODE_HI      = 19;
  localparam int FIS_CODE_LO      = 16;
  localparam int FIS_PARAM_HI     = 15;
  localparam int FIS_LOOP_CNT_HI  = 15;
  localparam int FIS_LOOP_CNT_LO  = 12;
  localparam int FIS_LOOP_ADDR_HI = 11;

  // ==========================================================================
  // Word type field encodings
  localparam logic [1:0] FIS_TYPE_READ  = 2'h0;
  localparam logic [1:0] FIS_TYPE_CMD   = 2'h1;
  localparam logic [1:0] FIS_TYPE_WRITE = 2'h2;
  localparam logic [1:0] FIS_TYPE_CTRL  = 2'h3;

  // Internal control codes
  localparam logic [3:0] FIS_CODE_LOOP    = 4'h1;
  localparam logic [3:0] FIS_CODE_WAIT    = 4'h2;
  localparam logic [3:0] FIS_CODE_SEQ_END = 4'h8;
  localparam logic [3:0] FIS_CODE_MEM_END = 4'hF;

  // ==========================================================================
  // Values after reset, and the last store index
  localparam logic [11:0] FIS_PC_RESET    = 12'h000;
  localparam logic [11:0] FIS_PC_LAST     = 12'hFFF;
  localparam logic [15:0] FIS_PAUSE_RESET = 16'h0000;
  localparam logic [3:0]  FIS_LOOP_RESET  = 4'h0;

  // One operation handed to the front-end bus
  typedef struct packed {
    logic [1:0]  kind;
    logic [19:0] instr;
    logic [19:0] data;
  } fis_fe_op_type;

  // Sequencer states
  typedef enum logic [1:0] {
    FIS_S_IDLE,
    FIS_S_EXEC,
    FIS_S_FRONTEND,
    FIS_S_PAUSE
  } fis_state_type;

endpackage

// ==== verilog/fis_sequencer.sv ====
// Front-end instruction sequencer: instruction store, decoder and flow control
`timescale 1ns/1ps

module fis_sequencer
  import fis_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  input  wire logic                  load_we_i,
  input  wire logic [FIS_ADDR_W-1:0] load_addr_i,
  input  wire logic [FIS_WORD_W-1:0] load_data_i,
  input  wire logic                  start_i,
  input  wire logic [FIS_ADDR_W-1:0] start_addr_i,
  input  wire logic                  fe_ack_i,
  output fis_fe_op_type              fe_op_o,
  output logic                       fe_req_o,
  output logic                       busy_o,
  output logic                       seq_done_o,
  output logic                       mem_end_o,
  output logic                       bad_word_o,
  output logic [FIS_ADDR_W-1:0]      pc_o
);

  // ==========================================================================
  // Storage and state
  logic [FIS_WORD_W-1:0]  store [FIS_DEPTH];
  fis_state_type          state;
  logic [FIS_ADDR_W-1:0]  pc;
  logic [FIS_PARAM_W-1:0] pause_cnt;
  logic [3:0]             loop_left;
  logic                   loop_active;

  // ==========================================================================
  // Word decode
  wire logic [FIS_WORD_W-1:0]  cur_word   = store[pc];
  wire logic [FIS_ADDR_W-1:0]  pc_plus1   = pc + 12'h001;
  wire logic [FIS_ADDR_W-1:0]  pc_plus2   = pc + 12'h002;
  wire logic [FIS_WORD_W-1:0]  pair_word  = store[pc_plus1];
  wire logic [1:0]             cur_type   = cur_word[FIS_TYPE_HI:FIS_TYPE_LO];
  wire logic                   is_ctrl    = (cur_type == FIS_TYPE_CTRL);
  wire logic [3:0]             cur_code   = cur_word[FIS_CODE_HI:FIS_CODE_LO];
  wire logic [FIS_PARAM_W-1:0] cur_param  = cur_word[FIS_PARAM_HI:0];
  wire logic [3:0]             loop_count = cur_word[FIS_LOOP_CNT_HI:FIS_LOOP_CNT_LO];
  wire logic [FIS_ADDR_W-1:0]  loop_ret   = cur_word[FIS_LOOP_ADDR_HI:0];
  wire logic                   at_last    = (pc == FIS_PC_LAST);

  // Execute-cycle qualifiers
  wire logic exec       = (state == FIS_S_EXEC);
  wire logic exec_fe    = exec && !is_ctrl;
  wire logic exec_write = exec_fe && (cur_type == FIS_TYPE_WRITE);
  wire logic orphan_wr  = exec_write && at_last;
  wire logic exec_loop  = exec && is_ctrl && (cur_code == FIS_CODE_LOOP);
  wire logic exec_wait  = exec && is_ctrl && (cur_code == FIS_CODE_WAIT);
  wire logic exec_send  = exec && is_ctrl && (cur_code == FIS_CODE_SEQ_END);
  wire logic exec_mend  = exec && is_ctrl && (cur_code == FIS_CODE_MEM_END);
  wire logic exec_bad   = exec && is_ctrl && !exec_loop && !exec_wait && !exec_send && !exec_mend;

  // Loop bookkeeping: first pass loads count-1 jumps, later passes count down
  wire logic [3:0] loop_first = loop_count - 4'h1;
  wire logic       loop_jump  = loop_active ? (loop_left != 4'h1) : (loop_count > 4'h1);
  wire logic [3:0] next_loop  = loop_active ? (loop_left - 4'h1) : loop_first;

  // Program counter selection
  wire logic [FIS_ADDR_W-1:0] next_pc =
      exec_write                              ? pc_plus2 :
      (exec_loop && loop_jump)                ? loop_ret :
      (exec_wait && cur_param != 16'h0000)    ? pc       :
      pc_plus1;

  // Index the program counter takes at the coming edge; pc_o follows it so the
  // status copy never lags the program counter at the end of a pause
  wire logic                  pause_last = (state == FIS_S_PAUSE) && (pause_cnt == 16'h0001);
  wire logic [FIS_ADDR_W-1:0] pc_follow  =
      (state == FIS_S_IDLE && start_i) ? start_addr_i :
      exec                             ? next_pc      :
      pause_last                       ? pc_plus1     :
      pc;

  // Front-end operation built from the current word
  wire fis_fe_op_type next_fe_op = '{kind:  cur_type,
                                     instr: cur_word[FIS_FE_HI:0],
                                     data:  exec_write ? pair_word[FIS_FE_HI:0] : 20'h00000};

  // ==========================================================================
  // Instruction store writes, only while the sequencer is idle
  always_ff @(posedge clk_sys_i) begin
    if (load_we_i && state == FIS_S_IDLE) begin
      store[load_addr_i] <= load_data_i;
    end
  end

  // ==========================================================================
  // Sequencer state machine
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state <= FIS_S_IDLE;
      pc    <= FIS_PC_RESET;
    end else begin
      unique case (state)
        FIS_S_IDLE: begin
          if (start_i) begin
            state <= FIS_S_EXEC;
            pc    <= start_addr_i;
          end
        end
        FIS_S_EXEC: begin
          pc <= next_pc;
          if (exec_send || exec_mend || orphan_wr) begin
            state <= FIS_S_IDLE;
          end else if (exec_fe) begin
            state <= FIS_S_FRONTEND;
          end else if (exec_wait && cur_param != 16'h0000) begin
            state <= FIS_S_PAUSE;
          end
        end
        FIS_S_FRONTEND: begin
          if (fe_ack_i) begin
            state <= FIS_S_EXEC;
          end
        end
        FIS_S_PAUSE: begin
          if (pause_cnt == 16'h0001) begin
            state <= FIS_S_EXEC;
            pc    <= pc_plus1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Pause counter
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pause_cnt <= FIS_PAUSE_RESET;
    end else if (exec_wait) begin
      pause_cnt <= cur_param;
    end else if (state == FIS_S_PAUSE) begin
      pause_cnt <= pause_cnt - 16'h0001;
    end
  end

  // ==========================================================================
  // Loop counter
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || state == FIS_S_IDLE) begin
      loop_left   <= FIS_LOOP_RESET;
      loop_active <= 1'b0;
    end else if (exec_loop) begin
      loop_left   <= next_loop;
      loop_active <= loop_jump;
    end
  end

  // ==========================================================================
  // Front-end request, held until acknowledged
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      fe_req_o <= 1'b0;
      fe_op_o  <= '0;
    end else if (exec_fe && !orphan_wr) begin
      fe_req_o <= 1'b1;
      fe_op_o  <= next_fe_op;
    end else if (fe_ack_i) begin
      fe_req_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Status outputs
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      busy_o     <= 1'b0;
      seq_done_o <= 1'b0;
      mem_end_o  <= 1'b0;
      bad_word_o <= 1'b0;
      pc_o       <= FIS_PC_RESET;
    end else begin
      busy_o     <= (state == FIS_S_IDLE) ? start_i : !(exec_send || exec_mend || orphan_wr);
      seq_done_o <= exec_send;
      mem_end_o  <= exec_mend;
      bad_word_o <= exec_bad || orphan_wr;
      pc_o       <= pc_follow;
    end
  end

  // ==========================================================================
  // Checks
  a_store_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (load_we_i && state == FIS_S_IDLE) |=> store[$past(load_addr_i)] == $past(load_data_i))
    else $error("store word not written");

  a_start_run: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state == FIS_S_IDLE && start_i) |=> (busy_o && pc == $past(start_addr_i) && state == FIS_S_EXEC))
    else $error("start did not launch sequence");

  a_fe_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (fe_req_o && !fe_ack_i) |=> (fe_req_o && $stable(fe_op_o)))
    else $error("front-end request dropped before ack");

  a_fe_forward: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_fe && !exec_write) |=> (fe_req_o && fe_op_o.kind == $past(cur_type)
                                  && pc == $past(pc_plus1)))
    else $error("front-end word not forwarded");

  a_write_pair: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_write && !at_last) |=> (fe_op_o.data == $past(pair_word[FIS_FE_HI:0]) && pc == $past(pc_plus2)))
    else $error("write data word not paired");

  a_ctrl_silent: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec && is_ctrl && !fe_req_o) |=> !fe_req_o)
    else $error("control word reached front-end bus");

  a_loop_jump: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_loop && !loop_active && loop_count > 4'h1)
      |=> (pc == $past(loop_ret) && loop_left == $past(loop_count) - 4'h1))
    else $error("loop did not jump back");

  a_loop_exit: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_loop && loop_active && loop_left == 4'h1) |=> (pc == $past(pc_plus1) && !loop_active))
    else $error("loop did not exit");

  a_pause_count: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_wait && cur_param == 16'h0003) |=> (state == FIS_S_PAUSE) [*3] ##1 state == FIS_S_EXEC)
    else $error("pause length wrong");

  a_seq_end: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    exec_send |=> (seq_done_o && !busy_o && state == FIS_S_IDLE))
    else $error("sequence end not honoured");

  a_mem_end: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    exec_mend |=> (mem_end_o && !busy_o && state == FIS_S_IDLE))
    else $error("memory end not honoured");

  a_bad_code: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    exec_bad |=> (bad_word_o && pc == $past(pc_plus1) && !fe_req_o))
    else $error("unknown control code not skipped");

  // ==========================================================================
  // Checks on hand-over, idle and status behaviour
  // Status copy of the index must never lag the program counter
  a_pc_mirror: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state != FIS_S_IDLE) |-> (pc_o == pc))
    else $error("pc status copy lags program counter");

  // A stale request after the acknowledge would repeat a front-end operation
  a_fe_release: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (fe_req_o && fe_ack_i) |=> (!fe_req_o && state == FIS_S_EXEC))
    else $error("front-end request not released after ack");

  a_fe_instr: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_fe && !orphan_wr) |=> (fe_op_o.instr == $past(cur_word[FIS_FE_HI:0])))
    else $error("front-end instruction field not forwarded");

  // The write word in the last location has no data word to pair with
  a_orphan_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    orphan_wr |=> (bad_word_o && !fe_req_o && !busy_o && state == FIS_S_IDLE))
    else $error("unpaired write word not refused");

  // A zero wait must cost only its decode cycle
  a_wait_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_wait && cur_param == 16'h0000) |=> (state == FIS_S_EXEC && pc == $past(pc_plus1)))
    else $error("zero wait did not continue");

  a_pause_quiet: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state == FIS_S_PAUSE) |-> !fe_req_o)
    else $error("front-end request during pause");

  a_loop_single: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (exec_loop && !loop_active && loop_count <= 4'h1)
      |=> (pc == $past(pc_plus1) && !loop_active))
    else $error("single-pass loop jumped back");

  // A load while running would change words the sequencer is about to fetch
  a_load_refused: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (load_we_i && state != FIS_S_IDLE)
      |=> (store[$past(load_addr_i)] == $past(store[load_addr_i])))
    else $error("store word changed while running");

  // Nothing may move between sequences except through a start
  a_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state == FIS_S_IDLE && !start_i)
      |=> (state == FIS_S_IDLE && !busy_o && !fe_req_o))
    else $error("sequencer left idle without start");

  a_busy_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (state != FIS_S_IDLE) |-> busy_o)
    else $error("busy low while sequence runs");

endmodule

// ==== testbench/fis_fe_model.sv ====
// Front-end bus controller model that answers sequencer requests
`timescale 1ns/1ps

module fis_fe_model (
  input  wire logic       clk_sys_i,
  input  wire logic       fe_req_i,
  input  wire logic [1:0] ack_delay_i,
  output logic            fe_ack_o
);
  // ==========================================================================
  // One acknowledge pulse per request, after a chosen number of stall cycles
  initial begin
    fe_ack_o = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      if (fe_req_i === 1'b1) begin
        repeat (ack_delay_i) @(posedge clk_sys_i);
        #1 fe_ack_o = 1'b1;
        @(posedge clk_sys_i);
        #1 fe_ack_o = 1'b0;
      end
    end
  end
endmodule

// ==== testbench/fis_sequencer_tb.sv ====
// Self-checking testbench for the front-end instruction sequencer
`timescale 1ns/1ps

module fis_sequencer_tb
  import fis_pkg::*;
;
  logic                  clk_sys_i = 1'b0;
  logic                  resetn_i = 1'b0;
  logic                  load_we_i = 1'b0;
  logic [FIS_ADDR_W-1:0] load_addr_i = '0;
  logic [FIS_WORD_W-1:0] load_data_i = '0;
  logic                  start_i = 1'b0;
  logic [FIS_ADDR_W-1:0] start_addr_i = '0;
  logic                  fe_ack_i;
  logic [1:0]            ack_delay = 2'h0;
  fis_fe_op_type         fe_op_o;
  logic                  fe_req_o, busy_o, seq_done_o, mem_end_o, bad_word_o;
  logic [FIS_ADDR_W-1:0] pc_o;
  logic [43:0]           exp_q[$];
  int                    num_errors = 0;
  int                    tests_run = 0;
  int                    t_base, t_wait, p, n;
  logic [19:0]           r [0:4];

  // ==========================================================================
  // Clock, design and bus partner
  always #4 clk_sys_i = ~clk_sys_i;
  fis_sequencer dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .load_we_i(load_we_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i), .start_i(start_i), .start_addr_i(start_addr_i),
    .fe_ack_i(fe_ack_i), .fe_op_o(fe_op_o), .fe_req_o(fe_req_o), .busy_o(busy_o), .seq_done_o(seq_done_o),
    .mem_end_o(mem_end_o), .bad_word_o(bad_word_o), .pc_o(pc_o));
  fis_fe_model fe_u (.clk_sys_i(clk_sys_i), .fe_req_i(fe_req_o), .ack_delay_i(ack_delay), .fe_ack_o(fe_ack_i));

  // ==========================================================================
  // Comparison and note handling
  task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pop(input logic [43:0] seen);
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("Error at %0t: unexpected result %h", $time, seen);
    end else begin
      chk(seen, exp_q.pop_front());
    end
  endtask
  task automatic note(input logic [1:0] ev, input logic [1:0] k, input logic [19:0] i, input logic [19:0] d);
    exp_q.push_back({ev, k, i, d});
  endtask

  // Monitor: every result takes the oldest note off the queue, sampled where outputs are settled
  always @(negedge clk_sys_i) begin
    if (resetn_i === 1'b1) begin
      if (fe_req_o === 1'b1 && fe_ack_i === 1'b1) pop({2'h0, fe_op_o});
      if (seq_done_o !== 1'b0) pop({2'h1, 42'h0});
      if (mem_end_o !== 1'b0) pop({2'h2, 42'h0});
      if (bad_word_o !== 1'b0) pop({2'h3, 42'h0});
    end
  end

  // ==========================================================================
  // Store load and sequence start
  task automatic ld(input logic [11:0] a, input logic [21:0] w);
    @(posedge clk_sys_i);
    #1;
    load_we_i = 1'b1;
    load_addr_i = a;
    load_data_i = w;
  endtask
  task automatic run(input logic [11:0] a, input logic hit, output int cyc);
    @(posedge clk_sys_i);
    #1;
    load_we_i = 1'b0;
    start_i = 1'b1;
    start_addr_i = a;
    ack_delay = 2'($urandom_range(3));
    @(posedge clk_sys_i);
    #1;
    chk({32'h0, pc_o}, {32'h0, a});
    start_i = hit;
    start_addr_i = 12'h020;
    load_we_i = hit;
    load_addr_i = 12'h006;
    load_data_i = {FIS_TYPE_CTRL, FIS_CODE_MEM_END, 16'h0000};
    cyc = 1;
    while (busy_o !== 1'b0 && cyc < 3000) begin
      @(posedge clk_sys_i);
      #1;
      start_i = 1'b0;
      load_we_i = 1'b0;
      cyc++;
    end
    if (cyc >= 3000) num_errors++;
  endtask

  task automatic stop_test;
    chk(44'(exp_q.size()), 44'h0);
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h92d66ad6));
    for (int i = 0; i < 5; i++) r[i] = 20'($urandom);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({38'h0, busy_o, fe_req_o, seq_done_o, mem_end_o, bad_word_o, |pc_o}, 44'h0);
    resetn_i = 1'b1;
    // Every word type, a three-pass loop, a paired write and an unknown code
    ld(12'h000, {FIS_TYPE_READ, r[0]});
    ld(12'h001, {FIS_TYPE_CMD, r[1]});
    ld(12'h002, {FIS_TYPE_CTRL, FIS_CODE_LOOP, 4'h3, 12'h001});
    ld(12'h003, {FIS_TYPE_WRITE, r[2]});
    ld(12'h004, {FIS_TYPE_CTRL, r[3]});
    ld(12'h005, {FIS_TYPE_CTRL, 4'h5, 16'h0000});
    ld(12'h006, {FIS_TYPE_CTRL, FIS_CODE_SEQ_END, 16'hFFFF});
    note(2'h0, FIS_TYPE_READ, r[0], 20'h0);
    repeat (3) note(2'h0, FIS_TYPE_CMD, r[1], 20'h0);
    note(2'h0, FIS_TYPE_WRITE, r[2], r[3]);
    note(2'h3, 2'h0, 20'h0, 20'h0);
    note(2'h1, 2'h0, 20'h0, 20'h0);
    run(12'h000, 1'b1, n);
    $display("Test flow done");
    // Pause length against a direct end of sequence
    ld(12'h010, {FIS_TYPE_CTRL, FIS_CODE_SEQ_END, 16'h0000});
    note(2'h1, 2'h0, 20'h0, 20'h0);
    run(12'h010, 1'b0, t_base);
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 0 : (i == 1) ? 3 : $urandom_range(60, 1);
      ld(12'h010, {FIS_TYPE_CTRL, FIS_CODE_WAIT, 16'(p)});
      ld(12'h011, {FIS_TYPE_CTRL, FIS_CODE_SEQ_END, 16'h0000});
      note(2'h1, 2'h0, 20'h0, 20'h0);
      run(12'h010, 1'b0, t_wait);
      chk(44'(t_wait), 44'(t_base + p + 1));
    end
    $display("Test pause done");
    // A loop that must not repeat, end of memory content, then a write word in the last location
    ld(12'h020, {FIS_TYPE_CMD, r[4]});
    ld(12'h021, {FIS_TYPE_CTRL, FIS_CODE_LOOP, 4'($urandom_range(1)), 12'h020});
    ld(12'h022, {FIS_TYPE_CTRL, FIS_CODE_MEM_END, 16'(r[4])});
    note(2'h0, FIS_TYPE_CMD, r[4], 20'h0);
    note(2'h2, 2'h0, 20'h0, 20'h0);
    run(12'h020, 1'b0, n);
    ld(12'hFFF, {FIS_TYPE_WRITE, r[0]});
    note(2'h3, 2'h0, 20'h0, 20'h0);
    run(12'hFFF, 1'b0, n);
    $display("Test ends done");
    repeat (4) @(posedge clk_sys_i);
    stop_test();
  end
endmodule
